// >>> common/mbrad_pkg.sv
// Purpose: shared constants and types for the register address decoder
// Assumes: 16-bit register words, word addresses on 16 bits
// Notes: info/config word tables are indexed by position in the arrays below
`default_nettype none
package mbrad_pkg;
  // address map boundaries
  localparam logic [15:0] IN_IMG_LO  = 16'h0000;
  localparam logic [15:0] IN_IMG_HI  = 16'h03e7;
  localparam logic [15:0] OUT_IMG_LO = 16'h03e8;
  localparam logic [15:0] OUT_IMG_HI = 16'h07cf;
  localparam logic [15:0] INHIB_LO   = 16'h07d0;
  localparam logic [15:0] INHIB_HI   = 16'h0fff;
  localparam logic [15:0] CFG_LO     = 16'h1000;
  localparam logic [15:0] CFG_HI     = 16'h2fff;
  localparam logic [15:0] FLAG_LO    = 16'h3000;
  localparam int          IMG_WORDS      = 1000;
  localparam int          FLAG_MAX_WORDS = 53248;

  // function codes of the register services
  localparam logic [7:0] FC_RD_HOLD  = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_ONE   = 8'h06;
  localparam logic [7:0] FC_WR_MULTI = 8'h10;
  localparam logic [7:0] FC_MASK_WR  = 8'h16;
  localparam logic [7:0] FC_RD_WR    = 8'h17;

  // exception codes
  localparam logic [7:0] EXC_NONE         = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;

  // read-only words fed from system state, in port order
  localparam int          INFO_WORDS = 17;
  localparam logic [15:0] INFO_ADDR [INFO_WORDS] = '{
    16'h1022, 16'h1023, 16'h1024, 16'h1025, 16'h1028, 16'h102a, 16'h1031, 16'h1032,
    16'h1033, 16'h1040, 16'h1101, 16'h2010, 16'h2011, 16'h2012, 16'h2013, 16'h2014, 16'h2015};
  // writable configuration words, in port order
  localparam int          RW_WORDS = 5;
  localparam logic [15:0] RW_ADDR  [RW_WORDS] = '{16'h1030, 16'h1037, 16'h1102, 16'h1103, 16'h1104};
  localparam logic [15:0] RW_RESET [RW_WORDS] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  // write-only watchdog command word
  localparam logic [15:0] WDOG_CMD_ADDR = 16'h1100;
  // constant test pattern words
  localparam int          CONST_WORDS = 9;
  localparam logic [15:0] CONST_ADDR [CONST_WORDS] = '{
    16'h2000, 16'h2001, 16'h2002, 16'h2003, 16'h2004, 16'h2005, 16'h2006, 16'h2007, 16'h2008};
  localparam logic [15:0] CONST_VAL  [CONST_WORDS] = '{
    16'h0000, 16'hffff, 16'h1234, 16'haaaa, 16'h5555, 16'h7fff, 16'h8000, 16'h3fff, 16'h4000};

  typedef enum logic [2:0] {
    REG_IN_IMG  = 3'h0,
    REG_OUT_IMG = 3'h1,
    REG_INHIB   = 3'h2,
    REG_CFG     = 3'h3,
    REG_FLAG    = 3'h4
  } mbrad_region_type;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01,
    ST_RESP   = 2'b11
  } mbrad_state_type;

  // address to region, shared by decode and response selection
  function automatic mbrad_region_type mbrad_region_of(input logic [15:0] addr);
    if (addr <= IN_IMG_HI)       return REG_IN_IMG;
    else if (addr <= OUT_IMG_HI) return REG_OUT_IMG;
    else if (addr <= INHIB_HI)   return REG_INHIB;
    else if (addr <= CFG_HI)     return REG_CFG;
    else                         return REG_FLAG;
  endfunction : mbrad_region_of
endpackage : mbrad_pkg
`default_nettype wire

// >>> hw/mbrad_cfg_regs.sv
// Purpose: information and configuration word window lookup and storage
// Assumes: lookup address and write strobe come from logic on ref_clk
// Notes: lookup is combinational; writes land on the clock edge
`timescale 1ns/1ps
`default_nettype none
module mbrad_cfg_regs (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [15:0] addr,
  input  wire logic        wr_en,
  input  wire logic [15:0] wdata,
  input  wire logic [16*mbrad_pkg::INFO_WORDS-1:0] info_words,
  output logic             defined,
  output logic             readable,
  output logic             writable,
  output logic [15:0]      rdata,
  output logic [16*mbrad_pkg::RW_WORDS-1:0] rw_words,
  output logic             wdog_cmd_stb,
  output logic [15:0]      wdog_cmd_word
);
  logic [15:0] rw_q [mbrad_pkg::RW_WORDS];
  logic [15:0] rw_d [mbrad_pkg::RW_WORDS];
  logic        cmd_stb_q;
  logic        cmd_stb_d;
  logic [15:0] cmd_word_q;
  logic [15:0] cmd_word_d;

  // table lookup: only listed words exist, everything else is a hole
  always_comb begin
    readable = 1'b0;
    writable = 1'b0;
    rdata    = 16'h0000;
    for (int i = 0; i < mbrad_pkg::INFO_WORDS; i++) begin
      if (addr == mbrad_pkg::INFO_ADDR[i]) begin
        readable = 1'b1;
        rdata    = info_words[16*i +: 16];
      end
    end
    for (int i = 0; i < mbrad_pkg::CONST_WORDS; i++) begin
      if (addr == mbrad_pkg::CONST_ADDR[i]) begin
        readable = 1'b1;
        rdata    = mbrad_pkg::CONST_VAL[i];
      end
    end
    for (int i = 0; i < mbrad_pkg::RW_WORDS; i++) begin
      if (addr == mbrad_pkg::RW_ADDR[i]) begin
        readable = 1'b1;
        writable = 1'b1;
        rdata    = rw_q[i];
      end
    end
    if (addr == mbrad_pkg::WDOG_CMD_ADDR) begin
      writable = 1'b1; // write-only, reads are refused
    end
    defined = readable | writable;
  end

  // next values of stored words and the command strobe
  always_comb begin
    cmd_stb_d  = 1'b0;
    cmd_word_d = cmd_word_q;
    for (int i = 0; i < mbrad_pkg::RW_WORDS; i++) begin
      rw_d[i] = (wr_en && addr == mbrad_pkg::RW_ADDR[i]) ? wdata : rw_q[i];
    end
    if (wr_en && addr == mbrad_pkg::WDOG_CMD_ADDR) begin
      cmd_stb_d  = 1'b1;
      cmd_word_d = wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int i = 0; i < mbrad_pkg::RW_WORDS; i++) begin
        rw_q[i] <= mbrad_pkg::RW_RESET[i];
      end
      cmd_stb_q  <= 1'b0;
      cmd_word_q <= 16'h0000;
    end else begin
      rw_q       <= rw_d;
      cmd_stb_q  <= cmd_stb_d;
      cmd_word_q <= cmd_word_d;
    end
  end

  for (genvar g = 0; g < mbrad_pkg::RW_WORDS; g++) begin : g_rw_out
    assign rw_words[16*g +: 16] = rw_q[g];
  end
  assign wdog_cmd_stb  = cmd_stb_q;
  assign wdog_cmd_word = cmd_word_q;
endmodule : mbrad_cfg_regs
`default_nettype wire

// >>> hw/mbrad_decoder.sv
// Purpose: word-level address decoder for register read/write services
// Assumes: one word per request; requester and controller on ref_clk
// Notes: holds both process images; flag words live outside (1-cycle read)
// Notes on behaviour
// - reads 0..999 return input image words
// - reads 1000..1999 return output image words
// - combined service there performs read only
// - reads 2000..4095 refused, illegal address
// - undefined config window reads refused
// - combined write only to writable config
// - 12288..65535 reach the flag area
// - writes 0..999 store into input image
// - writes 1000..4095 refused, except combined write part at 1000..1999; nothing modified
// - mask write refused in config window
// - config writes need defined writable word
// - read map shared by three read services
// - write map shared by four write services
`timescale 1ns/1ps
`default_nettype none
module mbrad_decoder #(
  parameter int IMG_WORDS = mbrad_pkg::IMG_WORDS
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_func,
  input  wire logic        req_wpart,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  input  wire logic [15:0] req_and_mask,
  input  wire logic [15:0] req_or_mask,
  output logic             resp_valid,
  output logic             resp_exc,
  output logic [7:0]       resp_exc_code,
  output logic [15:0]      resp_data,
  input  wire logic [15:0] flag_size,
  output logic             flag_rd,
  output logic             flag_wr,
  output logic [15:0]      flag_addr,
  output logic [15:0]      flag_wdata,
  input  wire logic [15:0] flag_rdata,
  input  wire logic [9:0]  ctl_in_addr,
  output logic [15:0]      ctl_in_rdata,
  input  wire logic        ctl_out_wr,
  input  wire logic [9:0]  ctl_out_addr,
  input  wire logic [15:0] ctl_out_wdata,
  input  wire logic [16*mbrad_pkg::INFO_WORDS-1:0] info_words,
  output logic [16*mbrad_pkg::RW_WORDS-1:0]        cfg_words,
  output logic             wdog_cmd_stb,
  output logic [15:0]      wdog_cmd_word
);
  // process images: input side written by the requester, output by controller
  logic [15:0] in_img  [IMG_WORDS];
  logic [15:0] out_img [IMG_WORDS];

  mbrad_pkg::mbrad_state_type  state_q, state_d;
  mbrad_pkg::mbrad_region_type region_q, region_d, region_c;
  logic        rd_q, rd_d;
  logic        wr_q, wr_d;
  logic        mask_q, mask_d;
  logic        exc_q, exc_d;
  logic [7:0]  code_q, code_d;
  logic [15:0] addr_q, addr_d;
  logic [9:0]  idx_q, idx_d;
  logic [15:0] wdata_q, wdata_d;
  logic [15:0] and_q, and_d;
  logic [15:0] or_q, or_d;
  logic [15:0] img_rd_q, img_rd_d;
  logic        ready_q, ready_d;
  logic        rv_q, rv_d;
  logic        rexc_q, rexc_d;
  logic [7:0]  rcode_q, rcode_d;
  logic [15:0] rdata_q, rdata_d;
  logic        frd_q, frd_d;
  logic        fwr_q, fwr_d;
  logic [15:0] faddr_q, faddr_d;
  logic [15:0] fwdata_q, fwdata_d;
  logic [15:0] ctl_rd_q;
  logic        in_we;
  logic [15:0] new_word;
  logic [15:0] cur_word;
  logic        is_read;
  logic        is_write;
  logic        take;
  logic [15:0] cfg_addr;
  logic        cfg_we;
  logic        cfg_readable;
  logic        cfg_writable;
  logic [15:0] cfg_rdata;
  logic [15:0] flag_idx;

  assign take     = req_valid && ready_q && state_q == mbrad_pkg::ST_IDLE;
  assign region_c = mbrad_pkg::mbrad_region_of(req_addr);
  assign flag_idx = req_addr - mbrad_pkg::FLAG_LO;
  // table looks at the new request while idle, at the held one afterwards
  assign cfg_addr = (state_q == mbrad_pkg::ST_IDLE) ? req_addr : addr_q;

  mbrad_cfg_regs u_cfg (
    .ref_clk       (ref_clk),
    .nrst          (nrst),
    .addr          (cfg_addr),
    .wr_en         (cfg_we),
    .wdata         (new_word),
    .info_words    (info_words),
    .defined       (),
    .readable      (cfg_readable),
    .writable      (cfg_writable),
    .rdata         (cfg_rdata),
    .rw_words      (cfg_words),
    .wdog_cmd_stb  (wdog_cmd_stb),
    .wdog_cmd_word (wdog_cmd_word)
  );

  // service classification: one read map, one write map
  always_comb begin
    is_read  = req_func == mbrad_pkg::FC_RD_HOLD || req_func == mbrad_pkg::FC_RD_INPUT
            || (req_func == mbrad_pkg::FC_RD_WR && !req_wpart);
    is_write = req_func == mbrad_pkg::FC_WR_ONE || req_func == mbrad_pkg::FC_WR_MULTI
            || req_func == mbrad_pkg::FC_MASK_WR
            || (req_func == mbrad_pkg::FC_RD_WR && req_wpart);
  end

  // decode on take; refused requests carry no access at all
  always_comb begin
    state_d  = state_q;
    region_d = region_q;
    rd_d     = rd_q;
    wr_d     = wr_q;
    mask_d   = mask_q;
    exc_d    = exc_q;
    code_d   = code_q;
    addr_d   = addr_q;
    idx_d    = idx_q;
    wdata_d  = wdata_q;
    and_d    = and_q;
    or_d     = or_q;
    frd_d    = 1'b0;
    faddr_d  = faddr_q;
    unique case (state_q)
      mbrad_pkg::ST_IDLE: begin
        if (take) begin
          state_d  = mbrad_pkg::ST_ACCESS;
          region_d = region_c;
          addr_d   = req_addr;
          wdata_d  = req_wdata;
          and_d    = req_and_mask;
          or_d     = req_or_mask;
          mask_d   = req_func == mbrad_pkg::FC_MASK_WR;
          idx_d    = (region_c == mbrad_pkg::REG_OUT_IMG) ? 10'(req_addr - mbrad_pkg::OUT_IMG_LO) : req_addr[9:0];
          rd_d     = 1'b0;
          wr_d     = 1'b0;
          exc_d    = 1'b1;
          code_d   = mbrad_pkg::EXC_ILLEGAL_ADDR;
          if (!is_read && !is_write) begin
            code_d = mbrad_pkg::EXC_ILLEGAL_FUNC; // unknown service
          end else begin
            unique case (region_c)
              mbrad_pkg::REG_IN_IMG: begin
                exc_d = 1'b0;
                rd_d  = is_read;
                wr_d  = is_write;
              end
              mbrad_pkg::REG_OUT_IMG: begin
                if (is_read) begin
                  exc_d = 1'b0;
                  rd_d  = 1'b1;
                end else if (req_func == mbrad_pkg::FC_RD_WR) begin
                  exc_d = 1'b0;
                end
                // other writes stay refused here
              end
              mbrad_pkg::REG_INHIB: begin
                exc_d = 1'b1;
              end
              mbrad_pkg::REG_CFG: begin
                if (is_read) begin
                  exc_d = !cfg_readable;
                  rd_d  = cfg_readable;
                end else if (req_func != mbrad_pkg::FC_MASK_WR && cfg_writable) begin
                  exc_d = 1'b0;
                  wr_d  = 1'b1;
                end
              end
              mbrad_pkg::REG_FLAG: begin
                if (flag_idx < flag_size) begin
                  exc_d   = 1'b0;
                  rd_d    = is_read;
                  wr_d    = is_write;
                  // mask write needs the old word first
                  frd_d   = is_read || req_func == mbrad_pkg::FC_MASK_WR;
                  faddr_d = flag_idx;
                end
              end
              default: begin
                exc_d = 1'b1;
              end
            endcase
          end
        end
      end
      mbrad_pkg::ST_ACCESS: begin
        state_d = mbrad_pkg::ST_RESP;
      end
      mbrad_pkg::ST_RESP: begin
        state_d = mbrad_pkg::ST_IDLE;
      end
      default: begin
        state_d = mbrad_pkg::ST_IDLE;
      end
    endcase
  end

  // response stage: merge masks, commit writes, present the answer
  always_comb begin
    img_rd_d = (region_q == mbrad_pkg::REG_OUT_IMG) ? out_img[idx_q] : in_img[idx_q];
    cur_word = (region_q == mbrad_pkg::REG_FLAG) ? flag_rdata : img_rd_q;
    new_word = mask_q ? ((cur_word & and_q) | (or_q & ~and_q)) : wdata_q;
    in_we    = state_q == mbrad_pkg::ST_RESP && wr_q && region_q == mbrad_pkg::REG_IN_IMG;
    cfg_we   = state_q == mbrad_pkg::ST_RESP && wr_q && region_q == mbrad_pkg::REG_CFG;
    fwr_d    = state_q == mbrad_pkg::ST_RESP && wr_q && region_q == mbrad_pkg::REG_FLAG;
    fwdata_d = fwr_d ? new_word : fwdata_q;
    rv_d     = state_q == mbrad_pkg::ST_RESP;
    rexc_d   = rv_d ? exc_q : rexc_q;
    rcode_d  = rv_d ? (exc_q ? code_q : mbrad_pkg::EXC_NONE) : rcode_q;
    rdata_d  = rdata_q;
    if (rv_d) begin
      rdata_d = 16'h0000;
      if (rd_q) begin
        unique case (region_q)
          mbrad_pkg::REG_CFG:  rdata_d = cfg_rdata;
          mbrad_pkg::REG_FLAG: rdata_d = flag_rdata;
          default:             rdata_d = img_rd_q;
        endcase
      end else if (wr_q) begin
        rdata_d = new_word; // echo of the stored word
      end
    end
    // idle only next cycle; blocks back-to-back so the pipeline never overlaps
    ready_d = state_d == mbrad_pkg::ST_IDLE;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q  <= mbrad_pkg::ST_IDLE;
      region_q <= mbrad_pkg::REG_IN_IMG;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      mask_q   <= 1'b0;
      exc_q    <= 1'b0;
      code_q   <= mbrad_pkg::EXC_NONE;
      addr_q   <= 16'h0000;
      idx_q    <= 10'h000;
      wdata_q  <= 16'h0000;
      and_q    <= 16'h0000;
      or_q     <= 16'h0000;
      img_rd_q <= 16'h0000;
      ready_q  <= 1'b0;
      rv_q     <= 1'b0;
      rexc_q   <= 1'b0;
      rcode_q  <= mbrad_pkg::EXC_NONE;
      rdata_q  <= 16'h0000;
      frd_q    <= 1'b0;
      fwr_q    <= 1'b0;
      faddr_q  <= 16'h0000;
      fwdata_q <= 16'h0000;
      ctl_rd_q <= 16'h0000;
    end else begin
      state_q  <= state_d;
      region_q <= region_d;
      rd_q     <= rd_d;
      wr_q     <= wr_d;
      mask_q   <= mask_d;
      exc_q    <= exc_d;
      code_q   <= code_d;
      addr_q   <= addr_d;
      idx_q    <= idx_d;
      wdata_q  <= wdata_d;
      and_q    <= and_d;
      or_q     <= or_d;
      img_rd_q <= img_rd_d;
      ready_q  <= ready_d;
      rv_q     <= rv_d;
      rexc_q   <= rexc_d;
      rcode_q  <= rcode_d;
      rdata_q  <= rdata_d;
      frd_q    <= frd_d;
      fwr_q    <= fwr_d;
      faddr_q  <= faddr_d;
      fwdata_q <= fwdata_d;
      ctl_rd_q <= in_img[ctl_in_addr];
    end
  end

  // image storage has no reset; contents are undefined until written
  always_ff @(posedge ref_clk) begin
    if (in_we) begin
      in_img[idx_q] <= new_word;
    end
    if (ctl_out_wr) begin
      out_img[ctl_out_addr] <= ctl_out_wdata;
    end
  end

  assign req_ready     = ready_q;
  assign resp_valid    = rv_q;
  assign resp_exc      = rexc_q;
  assign resp_exc_code = rcode_q;
  assign resp_data     = rdata_q;
  assign flag_rd       = frd_q;
  assign flag_wr       = fwr_q;
  assign flag_addr     = faddr_q;
  assign flag_wdata    = fwdata_q;
  assign ctl_in_rdata  = ctl_rd_q;
endmodule : mbrad_decoder
`default_nettype wire

// >>> tb/mbrad_flag_mem.sv
// Purpose: flag word memory on the far side of the decoder
// Assumes: accepted flag_addr below 256
// Notes: read data is valid one cycle only
`timescale 1ns/1ps
`default_nettype none
module mbrad_flag_mem (
  input  wire logic        ref_clk,
  input  wire logic        flag_rd,
  input  wire logic        flag_wr,
  input  wire logic [15:0] flag_addr,
  input  wire logic [15:0] flag_wdata,
  output logic [15:0]      flag_rdata
);
  logic [15:0] mem [256];
  // data toggles outside the read slot so a late sample shows up
  always @(posedge ref_clk) begin
    if (flag_wr) mem[flag_addr[7:0]] <= flag_wdata;
    flag_rdata <= flag_rd ? mem[flag_addr[7:0]] : ~flag_rdata;
  end
  initial flag_rdata = 16'h0000;
endmodule : mbrad_flag_mem
`default_nettype wire

// >>> tb/mbrad_chk.sv
// Purpose: port checker for the address decoder
// Assumes: flag_size steady during a request
// Notes: bound to every decoder instance
`timescale 1ns/1ps
`default_nettype none
module mbrad_chk #(parameter int IMG_WORDS = 1000) (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [7:0]  req_func,
  input wire logic        req_wpart,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic        resp_valid,
  input wire logic        resp_exc,
  input wire logic [7:0]  resp_exc_code,
  input wire logic [15:0] resp_data,
  input wire logic [15:0] flag_size,
  input wire logic        flag_rd,
  input wire logic        flag_wr,
  input wire logic [15:0] flag_addr,
  input wire logic [15:0] flag_rdata,
  input wire logic        wdog_cmd_stb,
  input wire logic [15:0] wdog_cmd_word
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // request decode helpers
  wire logic tk = req_valid && req_ready;
  wire logic rd = req_func == 8'h03 || req_func == 8'h04 || (req_func == 8'h17 && !req_wpart);
  wire logic [15:0] idx = req_addr - 16'h3000;
  wire logic fl = req_addr >= 16'h3000;
  wire logic bad = resp_exc && resp_exc_code == 8'h02;
  property p_lat; tk |=> !resp_valid ##1 !resp_valid ##1 resp_valid; endproperty
  a_lat: assert property (p_lat)
    else $error("answer not three cycles after take");
  property p_rd_inh; tk && rd && req_addr inside {[16'h07d0:16'h0fff]} |-> ##3 bad; endproperty
  a_rd_inh: assert property (p_rd_inh)
    else $error("inhibited read not refused");
  property p_wr_inh; tk && req_func inside {8'h06, 8'h10, 8'h16} && req_addr inside {[16'h03e8:16'h0fff]}
    |-> ##3 bad && !flag_wr; endproperty
  a_wr_inh: assert property (p_wr_inh)
    else $error("inhibited write not refused");
  property p_rw_out; tk && req_func == 8'h17 && req_wpart && req_addr inside {[16'h03e8:16'h07cf]}
    |-> ##3 !resp_exc && resp_data == 16'h0000; endproperty
  a_rw_out: assert property (p_rw_out)
    else $error("combined write part acted on output image");
  property p_mask_cfg; tk && req_func == 8'h16 && req_addr inside {[16'h1000:16'h2fff]} |-> ##3 bad; endproperty
  a_mask_cfg: assert property (p_mask_cfg)
    else $error("mask write accepted in config window");
  property p_flag_rd; tk && rd && fl && idx < flag_size |=> flag_rd && flag_addr == $past(idx); endproperty
  a_flag_rd: assert property (p_flag_rd)
    else $error("flag read not issued");
  property p_flag_dat; tk && rd && fl && idx < flag_size |-> ##3 resp_data == $past(flag_rdata); endproperty
  a_flag_dat: assert property (p_flag_dat)
    else $error("flag data not returned");
  property p_flag_over; tk && fl && idx >= flag_size |=> !flag_rd ##2 !flag_wr && bad; endproperty
  a_flag_over: assert property (p_flag_over)
    else $error("flag access beyond size not refused");
  property p_wdog; tk && req_func == 8'h06 && req_addr == 16'h1100
    |-> ##3 wdog_cmd_stb && wdog_cmd_word == $past(req_wdata, 3); endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog command not issued");
  property p_in_wr; tk && req_func == 8'h06 && req_addr < 16'h03e8
    |-> ##3 !resp_exc && resp_data == $past(req_wdata, 3); endproperty
  a_in_wr: assert property (p_in_wr)
    else $error("input image write not answered with word");
endmodule : mbrad_chk
bind mbrad_decoder mbrad_chk #(.IMG_WORDS(IMG_WORDS)) chk_i (.*);
`default_nettype wire

// >>> tb/tb_modbus_register_address_decoder.sv
// Purpose: self-checking bench for the address decoder
// Assumes: flag area of 64 words
// Notes: shadows of all storage predict every answer
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_register_address_decoder;
  logic ref_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_wpart = 1'b0, ctl_out_wr = 1'b0;
  logic [7:0] req_func = 8'h00;
  logic [15:0] req_addr = 16'h0, req_wdata = 16'h0, req_and_mask = 16'h0, req_or_mask = 16'h0;
  logic [15:0] flag_size = 16'h0040, ctl_out_wdata = 16'h0;
  logic [9:0] ctl_in_addr = 10'h000, ctl_out_addr = 10'h000;
  logic [16*17-1:0] info_words;
  logic req_ready, resp_valid, resp_exc, flag_rd, flag_wr, wdog_cmd_stb;
  logic [7:0] resp_exc_code;
  logic [15:0] resp_data, flag_addr, flag_wdata, flag_rdata, ctl_in_rdata, wdog_cmd_word;
  logic [16*5-1:0] cfg_words;
  logic [15:0] in_img [1000], out_img [1000], fsh [256], rw_sh [5], v, r;
  logic [31:0] seed = 32'h00000058;
  int failures = 0, n_checks = 0;
  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;
  mbrad_decoder uut (.ref_clk, .nrst, .req_valid, .req_ready, .req_func, .req_wpart, .req_addr,
    .req_wdata, .req_and_mask, .req_or_mask, .resp_valid, .resp_exc, .resp_exc_code, .resp_data,
    .flag_size, .flag_rd, .flag_wr, .flag_addr, .flag_wdata, .flag_rdata, .ctl_in_addr, .ctl_in_rdata,
    .ctl_out_wr, .ctl_out_addr, .ctl_out_wdata, .info_words, .cfg_words, .wdog_cmd_stb, .wdog_cmd_word);
  mbrad_flag_mem fmem (.ref_clk, .flag_rd, .flag_wr, .flag_addr, .flag_wdata, .flag_rdata);
  // xorshift source
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : xs
  // expected exception code from the address map
  function automatic logic [7:0] exp_code(input logic [7:0] f, input logic wp, input logic [15:0] a);
    logic rd, ok;
    rd = f == 8'h03 || f == 8'h04 || (f == 8'h17 && !wp);
    if (!(rd || f inside {8'h06, 8'h10, 8'h16, 8'h17})) return 8'h01;
    if (a < 16'h03e8) ok = 1'b1;
    else if (a < 16'h07d0) ok = rd || f == 8'h17;
    else if (a < 16'h1000) ok = 1'b0;
    else if (a < 16'h3000) begin
      ok = !rd && f != 8'h16 && a == mbrad_pkg::WDOG_CMD_ADDR;
      for (int i = 0; i < 5; i++) ok |= a == mbrad_pkg::RW_ADDR[i] && f != 8'h16;
      for (int i = 0; i < 17; i++) ok |= rd && a == mbrad_pkg::INFO_ADDR[i];
      for (int i = 0; i < 9; i++) ok |= rd && a == mbrad_pkg::CONST_ADDR[i];
    end else ok = a - 16'h3000 < flag_size;
    return ok ? 8'h00 : 8'h02;
  endfunction : exp_code
  // stored word at an address, from the shadows
  function automatic logic [15:0] old_w(input logic [15:0] a);
    old_w = 16'h0000;
    if (a < 16'h03e8) old_w = in_img[a];
    else if (a < 16'h07d0) old_w = out_img[a - 16'h03e8];
    else if (a >= 16'h3000) old_w = fsh[a[7:0]];
    for (int i = 0; i < 17; i++) if (a == mbrad_pkg::INFO_ADDR[i]) old_w = info_words[16*i +: 16];
    for (int i = 0; i < 5; i++) if (a == mbrad_pkg::RW_ADDR[i]) old_w = rw_sh[i];
    for (int i = 0; i < 9; i++) if (a == mbrad_pkg::CONST_ADDR[i]) old_w = mbrad_pkg::CONST_VAL[i];
  endfunction : old_w
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one word request: predict, drive, hold until taken, compare answer
  task automatic req(input logic [7:0] f, input logic [15:0] a, wd = 16'h0, am = 16'h0, om = 16'h0,
    input logic wp = 1'b0);
    logic [7:0] ec;
    logic [15:0] ed;
    int n;
    ec = exp_code(f, wp, a);
    ed = 16'h0000;
    if (ec == 8'h00) ed = old_w(a);
    if (ec == 8'h00 && (f inside {8'h06, 8'h10, 8'h16} || (f == 8'h17 && wp))) begin
      ed = f == 8'h16 ? (ed & am) | (om & ~am) : wd;
      if (a inside {[16'h03e8:16'h07cf]}) ed = 16'h0000;
      else if (a < 16'h03e8) in_img[a] = ed;
      else if (a >= 16'h3000) fsh[a[7:0]] = ed;
      for (int i = 0; i < 5; i++) if (a == mbrad_pkg::RW_ADDR[i]) rw_sh[i] = ed;
    end
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_func <= f;
    req_wpart <= wp;
    req_addr <= a;
    req_wdata <= wd;
    req_and_mask <= am;
    req_or_mask <= om;
    n = 0;
    do begin @(negedge ref_clk); n++; end while (req_ready !== 1'b1 && n < 20);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin @(negedge ref_clk); n++; end while (resp_valid !== 1'b1 && n < 8);
    chk({15'h0, resp_valid}, 16'h0001);
    chk({8'h00, resp_exc_code}, {8'h00, ec});
    chk({15'h0, resp_exc}, {15'h0, ec != 8'h00});
    chk(resp_data, ed);
  endtask : req
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // hang guard
  initial begin
    #100000;
    failures++;
    conclude();
  end
  // main sequence
  initial begin
    for (int i = 0; i < 17; i++) info_words[16*i +: 16] = xs();
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) chk(cfg_words[16*i +: 16], mbrad_pkg::RW_RESET[i]);
    for (int i = 0; i < 5; i++) rw_sh[i] = mbrad_pkg::RW_RESET[i];
    // output image filled from the controller side
    for (int i = 0; i < 1000; i++) begin
      @(posedge ref_clk);
      v = xs();
      out_img[i] = v;
      ctl_out_wr <= 1'b1;
      ctl_out_addr <= i[9:0];
      ctl_out_wdata <= v;
    end
    @(posedge ref_clk);
    ctl_out_wr <= 1'b0;
    for (int i = 0; i < 1000; i++) req(8'h10, i[15:0], xs());
    for (int i = 0; i < 64; i++) req(8'h06, 16'h3000 + i[15:0], xs());
    @(posedge ref_clk);
    ctl_in_addr <= 10'h3e7;
    repeat (2) @(negedge ref_clk);
    chk(ctl_in_rdata, in_img[999]);
    req(8'h03, 16'h0000);
    req(8'h17, 16'h03e7);
    req(8'h04, 16'h03e8);
    req(8'h17, 16'h07cf, 16'h5a5a, 16'h0, 16'h0, 1'b1);
    req(8'h03, 16'h07cf);
    req(8'h06, 16'h03e8, 16'h1111);
    req(8'h16, 16'h0fff, 16'h0, 16'h00ff, 16'h1234);
    req(8'h03, 16'h07d0);
    req(8'h17, 16'h0fff);
    req(8'h04, 16'h1000);
    req(8'h03, 16'h2fff);
    req(8'h03, 16'h1100);
    for (int i = 0; i < 17; i++) req(8'h03, mbrad_pkg::INFO_ADDR[i]);
    for (int i = 0; i < 9; i++) req(8'h04, mbrad_pkg::CONST_ADDR[i]);
    for (int i = 0; i < 5; i++) req(8'h17, mbrad_pkg::RW_ADDR[i], xs(), 16'h0, 16'h0, 1'b1);
    for (int i = 0; i < 5; i++) chk(cfg_words[16*i +: 16], rw_sh[i]);
    req(8'h17, 16'h1022, 16'h7777, 16'h0, 16'h0, 1'b1);
    req(8'h10, 16'h2000, 16'h7777);
    req(8'h06, 16'h1100, 16'h00a5);
    req(8'h16, 16'h1030, 16'h0, 16'h0f0f, 16'hffff);
    req(8'h03, 16'h303f);
    req(8'h04, 16'h3040);
    req(8'h06, 16'hffff, 16'h2222);
    req(8'h16, 16'h3005, 16'h0, 16'hf00f, 16'h0ff0);
    req(8'h16, 16'h0005, 16'h0, 16'h00ff, 16'hff00);
    req(8'h05, 16'h0000);
    // random mix, 80 flag words cross the size edge
    for (int i = 0; i < 400; i++) begin
      r = xs();
      v = xs();
      case (r[2:0] % 5)
        0: v = v % 16'd1000;
        1: v = 16'h03e8 + v % 16'd1000;
        2: v = 16'h07d0 + v % 16'd2096;
        3: v = 16'h1000 + v % 16'h2000;
        default: v = 16'h3000 + v % 16'd80;
      endcase
      req(r[7:5] == 3'h7 ? 8'h17 : mbrad_pkg::FC_RD_HOLD, v, xs(), xs(), xs(), r[8]);
      req(r[10:9] == 2'h0 ? 8'h06 : r[10:9] == 2'h1 ? 8'h10 : 8'h16, v, xs(), xs(), xs());
    end
    conclude();
  end
endmodule : tb_modbus_register_address_decoder
`default_nettype wire
